// [design/sscc_pkg.sv]
// package for the system status and cache control register bank
package sscc_pkg;
   // register byte addresses in the high address space, from 0x80000000
   localparam logic [31:0] SSCC_ADDR_CONFIG = 32'h80000024;
   localparam logic [31:0] SSCC_ADDR_FAILADDR = 32'h8000000C;
   localparam logic [31:0] SSCC_ADDR_FAILSTAT = 32'h80000010;
   localparam logic [31:0] SSCC_ADDR_CACHECTL = 32'h80000014;
   // configuration word fields
   localparam logic SSCC_CFG_PAGING = 1'h0;
   localparam logic SSCC_CFG_DEBUG = 1'h1;
   localparam logic SSCC_CFG_SDRAM = 1'h1;
   localparam logic [2:0] SSCC_CFG_WATCH = 3'h4;
   localparam logic SSCC_CFG_MAC = 1'h0;
   localparam logic [4:0] SSCC_CFG_NWIN = 5'h07;
   localparam logic [2:0] SSCC_CFG_ICSZ = 3'h3;
   localparam logic [1:0] SSCC_CFG_ILSZ = 2'h3;
   localparam logic [2:0] SSCC_CFG_DCSZ = 3'h3;
   localparam logic [1:0] SSCC_CFG_DLSZ = 2'h2;
   localparam logic SSCC_CFG_DIV = 1'h1;
   localparam logic SSCC_CFG_MUL = 1'h1;
   localparam logic SSCC_CFG_WDOG = 1'h1;
   localparam logic SSCC_CFG_MSTAT = 1'h1;
   localparam logic [1:0] SSCC_CFG_WPRT = 2'h1;
   // failure status field positions
   localparam int SSCC_FS_CORR = 9;
   localparam int SSCC_FS_HERR = 8;
   localparam int SSCC_FS_DIR = 7;
   localparam int SSCC_FS_MOD_LO = 3;
   localparam int SSCC_FS_SIZE_LO = 0;
   // module and size encodings
   localparam logic [3:0] SSCC_MOD_IU = 4'h0;
   localparam logic [3:0] SSCC_MOD_PCI_INIT = 4'h1;
   localparam logic [3:0] SSCC_MOD_PCI_TGT = 4'h2;
   localparam logic [3:0] SSCC_MOD_DEBUG = 4'h3;
   localparam logic [2:0] SSCC_SIZE_BYTE = 3'h0;
   localparam logic [2:0] SSCC_SIZE_HALF = 3'h1;
   localparam logic [2:0] SSCC_SIZE_WORD = 3'h2;
   localparam logic [2:0] SSCC_SIZE_DWORD = 3'h3;
   // cache control fixed fields and bit positions
   localparam logic [1:0] SSCC_CC_REPL = 2'h3;
   localparam logic [1:0] SSCC_CC_ISETS = 2'h3;
   localparam logic [1:0] SSCC_CC_DSETS = 2'h1;
   localparam logic [1:0] SSCC_CC_PBITS = 2'h2;
   localparam int SSCC_CC_SNOOP = 23;
   localparam int SSCC_CC_FLUSH_D = 22;
   localparam int SSCC_CC_FLUSH_I = 21;
   localparam int SSCC_CC_TEST_LO = 17;
   localparam int SSCC_CC_BURST = 16;
   localparam int SSCC_CC_IPEND = 15;
   localparam int SSCC_CC_DPEND = 14;
   localparam int SSCC_CC_CNT_LO = 6;
   localparam int SSCC_CC_FRZ_D = 5;
   localparam int SSCC_CC_FRZ_I = 4;
   localparam int SSCC_CC_DSTATE_LO = 2;
   localparam int SSCC_CC_ISTATE_LO = 0;
   // counter saturation value and cache state encodings
   localparam logic [1:0] SSCC_CNT_MAX = 2'h3;
   localparam logic [1:0] SSCC_STATE_RESET = 2'h0;
   localparam logic [1:0] SSCC_STATE_FROZEN = 2'h1;
   localparam logic [1:0] SSCC_STATE_ENABLED = 2'h3;
   // one hardware error report from the memory system
   typedef struct packed {
      logic valid;
      logic correctable;
      logic is_read;
      logic [3:0] module_id;
      logic [2:0] size;
      logic [31:0] addr;
   } sscc_err_t;
   // cache state as seen by a cache controller
   typedef enum logic [2:0] {
      SSCC_CS_OFF = 3'b001,
      SSCC_CS_FROZEN = 3'b010,
      SSCC_CS_ON = 3'b100
   } sscc_cstate_t;
endpackage

// [design/sscc_regs.sv]
// system status and cache control register bank
//
// Implementation choice: the strobed register port.
`timescale 1ns/100ps
// Summary of operation
// - configuration reports windows and cache geometry
// - failing address captures full access address
// - writes ignored while hardware error clear, except bit nine of failure status
// - correctable memory error sets bit nine
// - hardware error sources set bit eight
// - error flag sticky; capture only after clear
// - bit seven records read or write
// - bits six to three record module
// - bits two to zero record size
// - detail fields may update while flag set
// - cache control fixed geometry fields read-only
// - bit 23 enables data cache snooping
// - flush bits trigger flush, read zero
// - pending bits show flush in progress
// - test bits xored into diagnostic parity
// - bit 16 enables instruction burst fill
// - four counters count parity errors
// - counters saturate at three until cleared
// - freeze bits freeze cache on interrupt
// - state fields: disabled, frozen, enabled
module sscc_regs
   import sscc_pkg::*;
(
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // register port
   input wire logic [31:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   // error reports
   input wire sscc_err_t err_in,
   input wire logic regfile_err_in,
   // cache events
   input wire logic [3:0] parity_err_in,
   input wire logic irq_taken_in,
   input wire logic iflush_done_in,
   input wire logic dflush_done_in,
   input wire logic [1:0] diag_parity_in,
   // cache controls
   output logic snoop_enable_out,
   output logic burst_fetch_enable_out,
   output logic flush_icache_out,
   output logic flush_dcache_out,
   output logic [1:0] diag_parity_out,
   output logic icache_alloc_out,
   output logic dcache_alloc_out,
   output logic icache_on_out,
   output logic dcache_on_out
);
   logic [31:0] fail_addr_r;
   logic [9:0] fail_stat_r;
   logic snoop_r, burst_r, ipend_r, dpend_r;
   logic [1:0] test_r, istate_r, dstate_r;
   logic frz_d_r, frz_i_r;
   logic [1:0] cnt_r [4];
   logic flush_i_r, flush_d_r;
   logic wr_fa, wr_fs, wr_cc;
   logic [31:0] cfg_word, cc_word, rd_nxt;
   sscc_cstate_t icst, dcst;

   // write decode
   assign wr_fa = wr_in && addr_in == SSCC_ADDR_FAILADDR;
   assign wr_fs = wr_in && addr_in == SSCC_ADDR_FAILSTAT;
   assign wr_cc = wr_in && addr_in == SSCC_ADDR_CACHECTL;

   // fixed feature word, nothing writable
   assign cfg_word = {SSCC_CFG_PAGING, SSCC_CFG_DEBUG, SSCC_CFG_SDRAM, SSCC_CFG_WATCH,
      SSCC_CFG_MAC, SSCC_CFG_NWIN, SSCC_CFG_ICSZ, SSCC_CFG_ILSZ, SSCC_CFG_DCSZ,
      SSCC_CFG_DLSZ, SSCC_CFG_DIV, SSCC_CFG_MUL, SSCC_CFG_WDOG, SSCC_CFG_MSTAT,
      2'h1, 2'h1, SSCC_CFG_WPRT}; // fpu and pci type codes arbitrary

   // failing address: first error after a clear wins, software write only while flag set
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         fail_addr_r <= 32'h00000000;
      end else if (err_in.valid && !fail_stat_r[SSCC_FS_HERR]) begin
         fail_addr_r <= err_in.addr;
      end else if (wr_fa && fail_stat_r[SSCC_FS_HERR]) begin
         fail_addr_r <= wdata_in;
      end
   end

   // failure status; hardware set beats software clear in the same cycle
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         fail_stat_r <= 10'h000;
      end else begin
         if (wr_fs && fail_stat_r[SSCC_FS_HERR]) begin
            fail_stat_r <= wdata_in[9:0];
         end else if (wr_fs) begin
            fail_stat_r[SSCC_FS_CORR] <= wdata_in[SSCC_FS_CORR];
         end
         if (err_in.valid) begin
            fail_stat_r[SSCC_FS_HERR] <= 1'b1;
            // details refresh even while flag already set
            fail_stat_r[SSCC_FS_DIR] <= err_in.is_read;
            fail_stat_r[SSCC_FS_MOD_LO +: 4] <= err_in.module_id;
            fail_stat_r[SSCC_FS_SIZE_LO +: 3] <= err_in.size;
         end
         if (err_in.valid && err_in.correctable && !regfile_err_in) begin
            fail_stat_r[SSCC_FS_CORR] <= 1'b1;
         end
      end
   end

   // cache control writable fields
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         snoop_r <= 1'b0;
         burst_r <= 1'b0;
         test_r <= 2'h0;
         frz_d_r <= 1'b0;
         frz_i_r <= 1'b0;
      end else if (wr_cc) begin
         snoop_r <= wdata_in[SSCC_CC_SNOOP];
         burst_r <= wdata_in[SSCC_CC_BURST];
         test_r <= wdata_in[SSCC_CC_TEST_LO +: 2];
         frz_d_r <= wdata_in[SSCC_CC_FRZ_D];
         frz_i_r <= wdata_in[SSCC_CC_FRZ_I];
      end
   end

   // cache state; interrupt freeze of an already enabled cache overrides a same-cycle write
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         istate_r <= SSCC_STATE_RESET;
         dstate_r <= SSCC_STATE_RESET;
      end else begin
         if (wr_cc) begin
            istate_r <= wdata_in[SSCC_CC_ISTATE_LO +: 2];
            dstate_r <= wdata_in[SSCC_CC_DSTATE_LO +: 2];
         end
         if (irq_taken_in && frz_i_r && istate_r == SSCC_STATE_ENABLED) begin
            istate_r <= SSCC_STATE_FROZEN;
         end
         if (irq_taken_in && frz_d_r && dstate_r == SSCC_STATE_ENABLED) begin
            dstate_r <= SSCC_STATE_FROZEN;
         end
      end
   end

   // flush pulses and pending flags
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         flush_i_r <= 1'b0;
         flush_d_r <= 1'b0;
         ipend_r <= 1'b0;
         dpend_r <= 1'b0;
      end else begin
         flush_i_r <= wr_cc && wdata_in[SSCC_CC_FLUSH_I];
         flush_d_r <= wr_cc && wdata_in[SSCC_CC_FLUSH_D];
         if (wr_cc && wdata_in[SSCC_CC_FLUSH_I]) begin
            ipend_r <= 1'b1;
         end else if (iflush_done_in) begin
            ipend_r <= 1'b0;
         end
         if (wr_cc && wdata_in[SSCC_CC_FLUSH_D]) begin
            dpend_r <= 1'b1;
         end else if (dflush_done_in) begin
            dpend_r <= 1'b0;
         end
      end
   end

   // parity counters, index 3 instr tag down to 0 data sub-block
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_cnt
         always_ff @(posedge clock_in) begin
            if (rst_in) begin
               cnt_r[gi] <= 2'h0;
            end else if (parity_err_in[gi] && cnt_r[gi] != SSCC_CNT_MAX) begin
               // event beats a clear: count from the written value
               if (wr_cc) begin
                  cnt_r[gi] <= wdata_in[SSCC_CC_CNT_LO + 2*gi +: 2] + 2'h1;
               end else begin
                  cnt_r[gi] <= cnt_r[gi] + 2'h1;
               end
            end else if (wr_cc) begin
               cnt_r[gi] <= wdata_in[SSCC_CC_CNT_LO + 2*gi +: 2];
            end
         end
      end
   endgenerate

   // cache control read image
   assign cc_word = {SSCC_CC_REPL, SSCC_CC_REPL, SSCC_CC_ISETS, SSCC_CC_DSETS,
      snoop_r, 2'b00, SSCC_CC_PBITS, test_r, burst_r, ipend_r, dpend_r,
      cnt_r[3], cnt_r[2], cnt_r[1], cnt_r[0], frz_d_r, frz_i_r, dstate_r, istate_r};

   // read mux; unmapped addresses read zero
   always_comb begin
      rd_nxt = 32'h00000000;
      if (addr_in == SSCC_ADDR_CONFIG) begin
         rd_nxt = cfg_word;
      end else if (addr_in == SSCC_ADDR_FAILADDR) begin
         rd_nxt = fail_addr_r;
      end else if (addr_in == SSCC_ADDR_FAILSTAT) begin
         rd_nxt = {22'h000000, fail_stat_r};
      end else if (addr_in == SSCC_ADDR_CACHECTL) begin
         rd_nxt = cc_word;
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         rdata_out <= 32'h00000000;
      end else if (rd_in) begin
         rdata_out <= rd_nxt;
      end else begin
         rdata_out <= 32'h00000000;
      end
   end

   // decode state fields; low bit zero means disabled
   always_comb begin
      icst = SSCC_CS_OFF;
      dcst = SSCC_CS_OFF;
      if (istate_r == SSCC_STATE_ENABLED) begin
         icst = SSCC_CS_ON;
      end else if (istate_r[0]) begin
         icst = SSCC_CS_FROZEN;
      end
      if (dstate_r == SSCC_STATE_ENABLED) begin
         dcst = SSCC_CS_ON;
      end else if (dstate_r[0]) begin
         dcst = SSCC_CS_FROZEN;
      end
   end

   // frozen still serves hits but allocates nothing
   assign icache_on_out = icst != SSCC_CS_OFF;
   assign dcache_on_out = dcst != SSCC_CS_OFF;
   assign icache_alloc_out = icst == SSCC_CS_ON;
   assign dcache_alloc_out = dcst == SSCC_CS_ON;
   assign snoop_enable_out = snoop_r;
   assign burst_fetch_enable_out = burst_r;
   assign flush_icache_out = flush_i_r;
   assign flush_dcache_out = flush_d_r;
   // test bits flip the stored parity on diagnostic writes
   assign diag_parity_out = diag_parity_in ^ test_r;

   // checks
   a_herr_sticky: assert property (@(posedge clock_in) disable iff (rst_in)
      fail_stat_r[SSCC_FS_HERR] && !(wr_fs && !wdata_in[SSCC_FS_HERR])
      |=> fail_stat_r[SSCC_FS_HERR])
      else $error("hardware error flag dropped");
   a_err_sets: assert property (@(posedge clock_in) disable iff (rst_in)
      err_in.valid |=> fail_stat_r[SSCC_FS_HERR])
      else $error("error did not set flag");
   a_addr_hold: assert property (@(posedge clock_in) disable iff (rst_in)
      !fail_stat_r[SSCC_FS_HERR] && !err_in.valid |=> $stable(fail_addr_r))
      else $error("fail address changed while clear");
   a_addr_capture: assert property (@(posedge clock_in) disable iff (rst_in)
      err_in.valid && !fail_stat_r[SSCC_FS_HERR] |=> fail_addr_r == $past(err_in.addr))
      else $error("fail address not captured");
   a_corr_set: assert property (@(posedge clock_in) disable iff (rst_in)
      err_in.valid && err_in.correctable && !regfile_err_in |=> fail_stat_r[SSCC_FS_CORR])
      else $error("correctable flag not set");
   a_cnt_sat: assert property (@(posedge clock_in) disable iff (rst_in)
      cnt_r[0] == SSCC_CNT_MAX && !wr_cc |=> cnt_r[0] == SSCC_CNT_MAX)
      else $error("counter left saturation");
   a_flush_reads: assert property (@(posedge clock_in) disable iff (rst_in)
      rd_in && addr_in == SSCC_ADDR_CACHECTL |=> rdata_out[22:21] == 2'b00)
      else $error("flush bits read nonzero");
   a_ipend_flush: assert property (@(posedge clock_in) disable iff (rst_in)
      wr_cc && wdata_in[SSCC_CC_FLUSH_I] |=> ipend_r && flush_icache_out)
      else $error("icache flush not pending");
   a_irq_freeze: assert property (@(posedge clock_in) disable iff (rst_in)
      irq_taken_in && frz_d_r && dstate_r == SSCC_STATE_ENABLED
      |=> dstate_r == SSCC_STATE_FROZEN ##0 !dcache_alloc_out)
      else $error("data cache not frozen");
   a_cfg_fixed: assert property (@(posedge clock_in) disable iff (rst_in)
      rd_in && addr_in == SSCC_ADDR_CONFIG |=> rdata_out[24:20] == SSCC_CFG_NWIN)
      else $error("window count wrong");
   a_cfg_flags: assert property (@(posedge clock_in) disable iff (rst_in)
      rd_in && addr_in == SSCC_ADDR_CONFIG |=> rdata_out[31:25] == {SSCC_CFG_PAGING,
      SSCC_CFG_DEBUG, SSCC_CFG_SDRAM, SSCC_CFG_WATCH, SSCC_CFG_MAC})
      else $error("feature flags wrong");
   a_cfg_geom: assert property (@(posedge clock_in) disable iff (rst_in)
      rd_in && addr_in == SSCC_ADDR_CONFIG |=> rdata_out[19:10] == {SSCC_CFG_ICSZ,
      SSCC_CFG_ILSZ, SSCC_CFG_DCSZ, SSCC_CFG_DLSZ})
      else $error("cache geometry wrong");
   // failure status checks; software writes must not race a hardware event here
   a_addr_swrite: assert property (@(posedge clock_in) disable iff (rst_in)
      wr_fa && fail_stat_r[SSCC_FS_HERR] |=> fail_addr_r == $past(wdata_in))
      else $error("fail address write lost");
   a_stat_ignore: assert property (@(posedge clock_in) disable iff (rst_in)
      wr_fs && !fail_stat_r[SSCC_FS_HERR] && !err_in.valid
      |=> fail_stat_r[8:0] == $past(fail_stat_r[8:0]))
      else $error("status write taken while clear");
   a_corr_sticky: assert property (@(posedge clock_in) disable iff (rst_in)
      fail_stat_r[SSCC_FS_CORR] && !wr_fs |=> fail_stat_r[SSCC_FS_CORR])
      else $error("correctable flag dropped");
   a_corr_clear: assert property (@(posedge clock_in) disable iff (rst_in)
      wr_fs && !wdata_in[SSCC_FS_CORR] && !err_in.valid |=> !fail_stat_r[SSCC_FS_CORR])
      else $error("correctable flag not cleared");
   a_addr_keep: assert property (@(posedge clock_in) disable iff (rst_in)
      fail_stat_r[SSCC_FS_HERR] && !wr_fa |=> $stable(fail_addr_r))
      else $error("fail address moved while set");
   a_err_dir: assert property (@(posedge clock_in) disable iff (rst_in)
      err_in.valid |=> fail_stat_r[SSCC_FS_DIR] == $past(err_in.is_read))
      else $error("direction not recorded");
   a_err_module: assert property (@(posedge clock_in) disable iff (rst_in)
      err_in.valid |=> fail_stat_r[6:3] == $past(err_in.module_id))
      else $error("module not recorded");
   a_err_size: assert property (@(posedge clock_in) disable iff (rst_in)
      err_in.valid |=> fail_stat_r[2:0] == $past(err_in.size))
      else $error("size not recorded");
   // cache control checks
   a_cc_fixed: assert property (@(posedge clock_in) disable iff (rst_in)
      rd_in && addr_in == SSCC_ADDR_CACHECTL |=> rdata_out[31:24] == {SSCC_CC_REPL,
      SSCC_CC_REPL, SSCC_CC_ISETS, SSCC_CC_DSETS})
      else $error("cache geometry fields wrong");
   a_snoop_out: assert property (@(posedge clock_in) disable iff (rst_in)
      wr_cc |=> snoop_enable_out == $past(wdata_in[SSCC_CC_SNOOP]))
      else $error("snoop enable not written");
   a_dflush_pend: assert property (@(posedge clock_in) disable iff (rst_in)
      wr_cc && wdata_in[SSCC_CC_FLUSH_D] |=> dpend_r && flush_dcache_out)
      else $error("dcache flush not pending");
   a_dpend_done: assert property (@(posedge clock_in) disable iff (rst_in)
      dflush_done_in && !(wr_cc && wdata_in[SSCC_CC_FLUSH_D]) |=> !dpend_r)
      else $error("dcache pending stuck");
   a_ipend_done: assert property (@(posedge clock_in) disable iff (rst_in)
      iflush_done_in && !(wr_cc && wdata_in[SSCC_CC_FLUSH_I]) |=> !ipend_r)
      else $error("icache pending stuck");
   a_diag_xor: assert property (@(posedge clock_in) disable iff (rst_in)
      wr_cc |=> diag_parity_out == (diag_parity_in ^ $past(wdata_in[18:17])))
      else $error("test bits not applied");
   a_burst_out: assert property (@(posedge clock_in) disable iff (rst_in)
      wr_cc |=> burst_fetch_enable_out == $past(wdata_in[SSCC_CC_BURST]))
      else $error("burst enable not written");
   a_cnt_step: assert property (@(posedge clock_in) disable iff (rst_in)
      parity_err_in[3] && cnt_r[3] != SSCC_CNT_MAX && !wr_cc
      |=> cnt_r[3] == $past(cnt_r[3]) + 2'h1)
      else $error("tag counter missed event");
   a_cnt_hold: assert property (@(posedge clock_in) disable iff (rst_in)
      !parity_err_in[1] && !wr_cc |=> $stable(cnt_r[1]))
      else $error("counter moved without event");
   a_ifreeze: assert property (@(posedge clock_in) disable iff (rst_in)
      irq_taken_in && frz_i_r && istate_r == SSCC_STATE_ENABLED
      |=> istate_r == SSCC_STATE_FROZEN ##0 !icache_alloc_out)
      else $error("icache not frozen");
   a_no_freeze: assert property (@(posedge clock_in) disable iff (rst_in)
      irq_taken_in && !frz_d_r && !wr_cc |=> $stable(dstate_r))
      else $error("dcache frozen without enable");
   a_state_off: assert property (@(posedge clock_in) disable iff (rst_in)
      !istate_r[0] |-> !icache_on_out && !icache_alloc_out)
      else $error("disabled icache active");
   a_frozen_hits: assert property (@(posedge clock_in) disable iff (rst_in)
      dstate_r == SSCC_STATE_FROZEN |-> dcache_on_out && !dcache_alloc_out)
      else $error("frozen dcache allocates");
   // read data stands one cycle only
   a_rdata_idle: assert property (@(posedge clock_in) disable iff (rst_in)
      !rd_in |=> rdata_out == 32'h00000000)
      else $error("read data held too long");
endmodule

// [tb/sscc_regs_tb.sv]
// self-checking testbench for the system status and cache control bank
`timescale 1ns/100ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; \
   $display("BAD %0t got %h want %h", $time, got, exp); end end
module sscc_regs_tb;
   import sscc_pkg::*;
   logic clock_in = 1'b0;
   logic rst_in = 1'b1;
   logic [31:0] addr_in = '0;
   logic [31:0] wdata_in = '0;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic [31:0] rdata_out;
   sscc_err_t err_in = '0;
   logic regfile_err_in = 1'b0;
   logic [3:0] parity_err_in = '0;
   logic irq_taken_in = 1'b0;
   logic iflush_done_in = 1'b0;
   logic dflush_done_in = 1'b0;
   logic [1:0] diag_parity_in = 2'h3;
   logic snoop_enable_out, burst_fetch_enable_out, flush_icache_out, flush_dcache_out;
   logic [1:0] diag_parity_out;
   logic icache_alloc_out, dcache_alloc_out, icache_on_out, dcache_on_out;
   int error_cnt = 0;
   int num_checks = 0;
   int cyc = 0;
   sscc_regs DUT (.clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .err_in(err_in),
      .regfile_err_in(regfile_err_in), .parity_err_in(parity_err_in),
      .irq_taken_in(irq_taken_in), .iflush_done_in(iflush_done_in),
      .dflush_done_in(dflush_done_in), .diag_parity_in(diag_parity_in),
      .snoop_enable_out(snoop_enable_out), .burst_fetch_enable_out(burst_fetch_enable_out),
      .flush_icache_out(flush_icache_out), .flush_dcache_out(flush_dcache_out),
      .diag_parity_out(diag_parity_out), .icache_alloc_out(icache_alloc_out),
      .dcache_alloc_out(dcache_alloc_out), .icache_on_out(icache_on_out),
      .dcache_on_out(dcache_on_out));
   // 200 MHz clock
   always #2.5 clock_in = ~clock_in;
   // hang guard, whole run needs about a hundred cycles
   always @(posedge clock_in) begin
      cyc++;
      if (cyc > 5000) begin
         error_cnt++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // one write cycle, returns at the sampling edge
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clock_in);
      wr_in <= 1'b0;
   endtask
   // read, data looked at only in the cycle after the strobe
   task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clock_in);
      rd_in <= 1'b0;
      @(negedge clock_in);
      `CHK(rdata_out, exp)
      @(posedge clock_in);
   endtask
   // one-cycle event pulses on the status inputs
   task automatic ev(input sscc_err_t e, input logic rf, input logic [3:0] p, input logic [2:0] m);
      err_in <= e;
      regfile_err_in <= rf;
      parity_err_in <= p;
      {irq_taken_in, iflush_done_in, dflush_done_in} <= m;
      @(posedge clock_in);
      err_in <= '0;
      regfile_err_in <= 1'b0;
      parity_err_in <= '0;
      {irq_taken_in, iflush_done_in, dflush_done_in} <= 3'h0;
      @(posedge clock_in);
   endtask
   task automatic t_config();
      rdchk(SSCC_ADDR_CONFIG, 32'h7077BBD5);
      wr(SSCC_ADDR_CONFIG, 32'h00000000);
      rdchk(SSCC_ADDR_CONFIG, 32'h7077BBD5);
      wr(32'h80000028, 32'hFFFFFFFF);
      rdchk(32'h80000028, 32'h00000000);
      $display("config test done");
   endtask
   task automatic t_fail();
      wr(SSCC_ADDR_FAILSTAT, 32'h000000FF);
      rdchk(SSCC_ADDR_FAILSTAT, 32'h00000000);
      ev({1'b1, 1'b1, 1'b1, SSCC_MOD_PCI_TGT, SSCC_SIZE_DWORD, 32'h12345678}, 1'b0, 4'h0, 3'h0);
      rdchk(SSCC_ADDR_FAILSTAT, 32'h00000393);
      rdchk(SSCC_ADDR_FAILADDR, 32'h12345678);
      // second error while flag set: detail moves, address stays
      ev({1'b1, 1'b0, 1'b0, SSCC_MOD_DEBUG, SSCC_SIZE_HALF, 32'hCAFE0000}, 1'b0, 4'h0, 3'h0);
      rdchk(SSCC_ADDR_FAILSTAT, 32'h00000319);
      rdchk(SSCC_ADDR_FAILADDR, 32'h12345678);
      wr(SSCC_ADDR_FAILSTAT, 32'h00000000);
      rdchk(SSCC_ADDR_FAILSTAT, 32'h00000000);
      // register-file error must not touch the correctable flag
      ev({1'b1, 1'b1, 1'b0, SSCC_MOD_IU, SSCC_SIZE_WORD, 32'h0000ABC0}, 1'b1, 4'h0, 3'h0);
      rdchk(SSCC_ADDR_FAILSTAT, 32'h00000102);
      rdchk(SSCC_ADDR_FAILADDR, 32'h0000ABC0);
      for (int i = 0; i < 4; i++) begin
         ev({1'b1, 1'b0, 1'b1, 4'(i), 3'(i), 32'h0}, 1'b0, 4'h0, 3'h0);
         rdchk(SSCC_ADDR_FAILSTAT, 32'h180 | (i << 3) | i);
      end
      $display("fail status test done");
   endtask
   task automatic t_cache();
      rdchk(SSCC_ADDR_CACHECTL, 32'hFD100000);
      wr(SSCC_ADDR_CACHECTL, 32'h0085003F);
      @(negedge clock_in);
      `CHK({snoop_enable_out, burst_fetch_enable_out}, 2'h3)
      `CHK(diag_parity_out, 2'h1)
      `CHK({icache_on_out, dcache_on_out, icache_alloc_out, dcache_alloc_out}, 4'hF)
      rdchk(SSCC_ADDR_CACHECTL, 32'hFD95003F);
      // flush both, pulses one cycle after the write
      wr(SSCC_ADDR_CACHECTL, 32'h00E5003F);
      @(negedge clock_in);
      `CHK({flush_icache_out, flush_dcache_out}, 2'h3)
      @(negedge clock_in);
      `CHK({flush_icache_out, flush_dcache_out}, 2'h0)
      rdchk(SSCC_ADDR_CACHECTL, 32'hFD95C03F);
      ev('0, 1'b0, 4'h0, 3'h3);
      rdchk(SSCC_ADDR_CACHECTL, 32'hFD95003F);
      // four hits on every counter, must stick at three
      for (int i = 0; i < 4; i++) begin
         ev('0, 1'b0, 4'hF, 3'h0);
      end
      rdchk(SSCC_ADDR_CACHECTL, 32'hFD953FFF);
      wr(SSCC_ADDR_CACHECTL, 32'h0085003F);
      ev('0, 1'b0, 4'h8, 3'h0);
      rdchk(SSCC_ADDR_CACHECTL, 32'hFD95103F);
      // interrupt with freeze bits set
      ev('0, 1'b0, 4'h0, 3'h4);
      rdchk(SSCC_ADDR_CACHECTL, 32'hFD951035);
      `CHK({icache_on_out, dcache_on_out, icache_alloc_out, dcache_alloc_out}, 4'hC)
      wr(SSCC_ADDR_CACHECTL, 32'h0085000F);
      ev('0, 1'b0, 4'h0, 3'h4);
      rdchk(SSCC_ADDR_CACHECTL, 32'hFD95000F);
      wr(SSCC_ADDR_CACHECTL, 32'h0085000A);
      @(negedge clock_in);
      `CHK({icache_on_out, dcache_on_out, icache_alloc_out, dcache_alloc_out}, 4'h0)
      $display("cache control test done");
   endtask
   // reset, then the scenarios in turn
   initial begin
      repeat (6) @(posedge clock_in);
      rst_in <= 1'b0;
      @(posedge clock_in);
      t_config();
      t_fail();
      t_cache();
      complete_run();
   end
endmodule
